/* rss_pkg.sv */
// shared constants and types of the regulator startup sequencer
package rss_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int OSC_MHZ = 48;
   localparam int PREBIAS_HOLD_PERIODS = 16;
   localparam logic [3:0] LS_DUTY_FIRST = 4'h1;
   localparam logic [3:0] LS_DUTY_FULL = 4'h8;
   localparam logic [4:0] PERIOD_CNT_LAST = 5'h0f;

   // ---------------------------------------------------------------
   // configuration memory layout and reset values
   // ---------------------------------------------------------------
   localparam int MEM_WORDS = 5;
   localparam logic [2:0] MEM_IDX_I2C = 3'h0;
   localparam logic [2:0] MEM_IDX_SMBUS = 3'h1;
   localparam logic [2:0] MEM_IDX_ONOFF = 3'h2;
   localparam logic [2:0] MEM_IDX_VIN_ON = 3'h3;
   localparam logic [2:0] MEM_IDX_VIN_OFF = 3'h4;
   localparam logic [2:0] MEM_IDX_LAST = 3'h4;
   localparam logic [6:0] I2C_BASE_RESET = 7'h10;
   localparam logic [6:0] SMBUS_BASE_RESET = 7'h40;
   // 250 mV per code, 8'h04 is the 1 V lockout default
   localparam logic [7:0] VIN_LIMIT_RESET = 8'h04;
   localparam logic [1:0] ONOFF_RESET = 2'h0;
   localparam int ONOFF_SOFT_SEL = 0;
   localparam int ONOFF_SOFT_ON = 1;

   // ---------------------------------------------------------------
   // command register codes
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_I2C_BASE = 8'h00;
   localparam logic [7:0] REG_SMBUS_BASE = 8'h01;
   localparam logic [7:0] REG_ONOFF = 8'h02;
   localparam logic [7:0] REG_VIN_ON = 8'h03;
   localparam logic [7:0] REG_VIN_OFF = 8'h04;
   localparam logic [7:0] REG_READ_VIN = 8'h05;
   localparam logic [7:0] REG_STATUS = 8'h06;

   // ---------------------------------------------------------------
   // strap converter bins: fifteen rising boundaries, 10-bit codes
   // ---------------------------------------------------------------
   localparam int STRAP_BINS = 16;
   localparam logic [9:0] STRAP_BOUND [0:14] = '{
      10'h020, 10'h060, 10'h0a0, 10'h0e0, 10'h120, 10'h160, 10'h1a0,
      10'h1e0, 10'h220, 10'h260, 10'h2a0, 10'h2e0, 10'h320, 10'h360,
      10'h3a0};

   typedef enum logic [1:0] {
      ST_RESET,
      ST_LOAD,
      ST_ADDR,
      ST_READY
   } rss_state_type;

endpackage : rss_pkg

/* rss_strap_decode.sv */
// strap converter reading to address offset
`timescale 1ns/1ps
module rss_strap_decode import rss_pkg::*; (
   input wire logic [9:0] adcValue,
   output logic [3:0] offset
);

   // ---------------------------------------------------------------
   // count the boundaries at or below the reading
   // ---------------------------------------------------------------
   always_comb begin
      offset = 4'h0;
      for (int i = 0; i < STRAP_BINS - 1; i++) begin
         if (adcValue >= STRAP_BOUND[i]) begin
            offset = offset + 4'h1;
         end
      end
   end

endmodule : rss_strap_decode

/* rss_sequencer.sv */
// startup sequencer: reset hold, config load, address, enable, pre-bias
// Behaviour
// - hold internal reset until both rails good and oscillator stable.
// - after reset, copy every config memory word into working registers.
// - after loading, accept bus commands regardless of the enable pin.
// - default enable needs pin, input above lockout, loaded, address read.
// - in digital mode software options may override the default enable.
// - keep separate 7-bit base addresses for the two bus ports.
// - a zero base address disables its port.
// - base defaults 0x10 and 0x40, strap offset added to each.
// - read strap with 10-bit converter, decode to offset 0 to 15.
// - answer commands at base plus offset after loading: digital mode.
// - floating strap: ignore commands, hand three pins to analog use.
// - in analog mode loaded configuration stays fixed.
// - input lockout defaults to 1 V, replaceable by on/off limits.
// - digitized input voltage is readback only; lockout uses comparators.
// - pre-charged start: low side off until first high-side pulse.
// - low side starts at 1/8 duty, steps 1/8 every 16 periods.
`timescale 1ns/1ps
module rss_sequencer import rss_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic mainRailGood,
   input wire logic coreRailGood,
   input wire logic oscStable,
   input wire logic enablePin,
   input wire logic vinAboveOn,
   input wire logic vinBelowOff,
   input wire logic strapFloating,
   input wire logic [9:0] strapAdcValue,
   input wire logic strapAdcValid,
   input wire logic [9:0] vinAdcValue,
   input wire logic [7:0] memData,
   input wire logic memValid,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [6:0] cmdTarget,
   input wire logic [7:0] cmdReg,
   input wire logic [7:0] cmdWrData,
   input wire logic highSideGate,
   input wire logic periodStart,
   output logic porActive,
   output logic memRead,
   output logic [2:0] memAddr,
   output logic [6:0] i2cAddr,
   output logic [6:0] smbusAddr,
   output logic digitalMode,
   output logic commPinsAnalog,
   output logic [7:0] vinOnLimit,
   output logic [7:0] vinOffLimit,
   output logic cmdAck,
   output logic [7:0] cmdRdData,
   output logic convEnable,
   output logic lowSideOn,
   output logic [3:0] lowSideDuty
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [6:0] syncA;
   logic [6:0] syncB;
   always_ff @(posedge ref_clk) begin
      syncA <= {strapFloating, vinBelowOff, vinAboveOn, enablePin,
                oscStable, coreRailGood, mainRailGood};
      syncB <= syncA;
   end
   wire logic suppliesGood = syncB[0] & syncB[1] & syncB[2];
   wire logic enSync = syncB[3];
   wire logic aboveOnSync = syncB[4];
   wire logic belowOffSync = syncB[5];
   wire logic floatSync = syncB[6];

   // ---------------------------------------------------------------
   // working registers and state
   // ---------------------------------------------------------------
   rss_state_type state;
   rss_state_type next_state;
   logic [6:0] i2cBase;
   logic [6:0] smbusBase;
   logic [1:0] onOffCfg;
   logic [3:0] strapOffset;
   logic inputOk;
   logic [3:0] decodedOffset;
   logic [4:0] periodCnt;
   logic seenHighSide;

   rss_strap_decode u_rss_strap_decode (
      .adcValue(strapAdcValue),
      .offset(decodedOffset)
   );

   function automatic logic [6:0] effAddr(input logic [6:0] base,
                                          input logic [3:0] off);
      effAddr = base + {3'h0, off};
   endfunction : effAddr

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire logic ready = (state == ST_READY);
   wire logic memHit = (state == ST_LOAD) & memValid;
   wire logic lastWord = (memAddr == MEM_IDX_LAST);
   wire logic i2cHit = (i2cBase != 7'h00) & (cmdTarget == i2cAddr);
   wire logic smbusHit = (smbusBase != 7'h00)
                         & (cmdTarget == smbusAddr);
   wire logic cmdTaken = cmdValid & ready & digitalMode
                         & (i2cHit | smbusHit);
   wire logic cmdWr = cmdTaken & cmdWrite;
   wire logic softSel = digitalMode & onOffCfg[ONOFF_SOFT_SEL];
   wire logic enableTerm = softSel ? onOffCfg[ONOFF_SOFT_ON] : enSync;
   wire logic next_conv = ready & inputOk & enableTerm;
   wire logic [7:0] statusWord = {3'h0, convEnable, digitalMode,
                                  inputOk, state};

   always_comb begin
      case (state)
         ST_RESET: next_state = suppliesGood ? ST_LOAD : ST_RESET;
         ST_LOAD: next_state = (memHit & lastWord) ? ST_ADDR : ST_LOAD;
         ST_ADDR: next_state = strapAdcValid ? ST_READY : ST_ADDR;
         ST_READY: next_state = ST_READY;
         default: next_state = ST_RESET;
      endcase
   end

   // ---------------------------------------------------------------
   // sequence state, reset hold and memory load
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst | ~suppliesGood) begin
         state <= ST_RESET;
         porActive <= 1'b1;
         memRead <= 1'b0;
         memAddr <= MEM_IDX_I2C;
      end else begin
         state <= next_state;
         porActive <= 1'b0;
         memRead <= (next_state == ST_LOAD);
         if (memHit & ~lastWord) begin
            memAddr <= memAddr + 3'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // strap latch and mode
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst | ~suppliesGood) begin
         strapOffset <= 4'h0;
         digitalMode <= 1'b0;
         commPinsAnalog <= 1'b0;
      end else if (state == ST_ADDR && strapAdcValid) begin
         strapOffset <= decodedOffset;
         digitalMode <= ~floatSync;
         commPinsAnalog <= floatSync;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         i2cAddr <= I2C_BASE_RESET;
         smbusAddr <= SMBUS_BASE_RESET;
      end else begin
         i2cAddr <= effAddr(i2cBase, strapOffset);
         smbusAddr <= effAddr(smbusBase, strapOffset);
      end
   end

   // ---------------------------------------------------------------
   // working configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         i2cBase <= I2C_BASE_RESET;
         smbusBase <= SMBUS_BASE_RESET;
         onOffCfg <= ONOFF_RESET;
         vinOnLimit <= VIN_LIMIT_RESET;
         vinOffLimit <= VIN_LIMIT_RESET;
      end else if (memHit) begin
         case (memAddr)
            MEM_IDX_I2C: i2cBase <= memData[6:0];
            MEM_IDX_SMBUS: smbusBase <= memData[6:0];
            MEM_IDX_ONOFF: onOffCfg <= memData[1:0];
            MEM_IDX_VIN_ON: vinOnLimit <= memData;
            MEM_IDX_VIN_OFF: vinOffLimit <= memData;
            default: onOffCfg <= onOffCfg;
         endcase
      end else if (cmdWr) begin
         case (cmdReg)
            REG_I2C_BASE: i2cBase <= cmdWrData[6:0];
            REG_SMBUS_BASE: smbusBase <= cmdWrData[6:0];
            REG_ONOFF: onOffCfg <= cmdWrData[1:0];
            REG_VIN_ON: vinOnLimit <= cmdWrData;
            REG_VIN_OFF: vinOffLimit <= cmdWrData;
            default: onOffCfg <= onOffCfg;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // command answer
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmdAck <= 1'b0;
         cmdRdData <= 8'h00;
      end else begin
         cmdAck <= cmdTaken;
         if (cmdTaken & ~cmdWrite) begin
            case (cmdReg)
               REG_I2C_BASE: cmdRdData <= {1'b0, i2cBase};
               REG_SMBUS_BASE: cmdRdData <= {1'b0, smbusBase};
               REG_ONOFF: cmdRdData <= {6'h00, onOffCfg};
               REG_VIN_ON: cmdRdData <= vinOnLimit;
               REG_VIN_OFF: cmdRdData <= vinOffLimit;
               REG_READ_VIN: cmdRdData <= vinAdcValue[9:2];
               REG_STATUS: cmdRdData <= statusWord;
               default: cmdRdData <= 8'h00;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // input lockout from comparators and conversion enable
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inputOk <= 1'b0;
         convEnable <= 1'b0;
      end else begin
         if (aboveOnSync) begin
            inputOk <= 1'b1;
         end else if (belowOffSync) begin
            inputOk <= 1'b0;
         end
         convEnable <= next_conv;
      end
   end

   // ---------------------------------------------------------------
   // pre-bias low-side ramp
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst | ~convEnable) begin
         seenHighSide <= 1'b0;
         lowSideOn <= 1'b0;
         lowSideDuty <= 4'h0;
         periodCnt <= 5'h00;
      end else if (~seenHighSide) begin
         if (highSideGate) begin
            seenHighSide <= 1'b1;
            lowSideOn <= 1'b1;
            lowSideDuty <= LS_DUTY_FIRST;
         end
      end else if (periodStart && lowSideDuty != LS_DUTY_FULL) begin
         if (periodCnt == PERIOD_CNT_LAST) begin
            periodCnt <= 5'h00;
            lowSideDuty <= lowSideDuty + 4'h1;
         end else begin
            periodCnt <= periodCnt + 5'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_por_hold;
      @(posedge ref_clk) disable iff (rst)
         ~suppliesGood |=> porActive;
   endproperty
   a_por_hold: assert property (p_por_hold)
      else $error("reset released while supplies not good");

   property p_load_words;
      @(posedge ref_clk) disable iff (rst)
         (state == ST_LOAD && next_state == ST_ADDR) |-> lastWord;
   endproperty
   a_load_words: assert property (p_load_words)
      else $error("load ended before the last word");

   property p_conv_cond;
      @(posedge ref_clk) disable iff (rst)
         convEnable |-> $past(ready) && $past(inputOk);
   endproperty
   a_conv_cond: assert property (p_conv_cond)
      else $error("conversion enabled without its conditions");

   property p_default_pin;
      @(posedge ref_clk) disable iff (rst)
         (~softSel && ~enSync) |=> ~convEnable;
   endproperty
   a_default_pin: assert property (p_default_pin)
      else $error("conversion enabled with pin low");

   property p_zero_base;
      @(posedge ref_clk) disable iff (rst)
         (smbusBase == 7'h00 && cmdValid && cmdTarget == smbusAddr
            && cmdTarget != i2cAddr) |=> ~cmdAck;
   endproperty
   a_zero_base: assert property (p_zero_base)
      else $error("command taken on a zero base address");

   property p_analog_quiet;
      @(posedge ref_clk) disable iff (rst)
         commPinsAnalog |-> ##1 (~cmdAck && $stable(i2cBase)
            && $stable(vinOnLimit));
   endproperty
   a_analog_quiet: assert property (p_analog_quiet)
      else $error("analog mode answered or changed config");

   property p_addr_sum;
      @(posedge ref_clk) disable iff (rst)
         ready |=> i2cAddr == effAddr($past(i2cBase), $past(strapOffset));
   endproperty
   a_addr_sum: assert property (p_addr_sum)
      else $error("address is not base plus offset");

   property p_offset_latched;
      @(posedge ref_clk) disable iff (rst)
         $past(ready) && ready |-> $stable(strapOffset);
   endproperty
   a_offset_latched: assert property (p_offset_latched)
      else $error("strap offset changed after latch");

   property p_ls_wait;
      @(posedge ref_clk) disable iff (rst)
         (convEnable && ~seenHighSide && ~highSideGate) |=> ~lowSideOn;
   endproperty
   a_ls_wait: assert property (p_ls_wait)
      else $error("low side on before first high-side pulse");

   sequence s_step;
      periodStart && convEnable && lowSideOn && periodCnt == PERIOD_CNT_LAST
         && lowSideDuty != LS_DUTY_FULL;
   endsequence
   property p_ls_step;
      @(posedge ref_clk) disable iff (rst)
         s_step ##1 convEnable |-> lowSideDuty == $past(lowSideDuty) + 4'h1;
   endproperty
   a_ls_step: assert property (p_ls_step)
      else $error("low side duty did not step");

endmodule : rss_sequencer

/* rss_far_side_model.sv */
// config memory and strap converter model facing the sequencer
`timescale 1ns/1ps
module rss_far_side_model import rss_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic memRead,
   input wire logic [2:0] memAddr,
   input wire logic slow,
   input wire logic [39:0] memImage,
   input wire logic [9:0] strapCode,
   output logic [7:0] memData,
   output logic memValid,
   output logic [9:0] strapAdcValue,
   output logic strapAdcValid
);
   // ---------------------------------------------------------------
   // word answers, idle data lines toggle to stay meaningless
   // ---------------------------------------------------------------
   logic [1:0] waitCnt;
   logic seenLoad;
   logic strapDone;
   always @(posedge ref_clk) begin
      if (rst) begin
         memValid <= 1'b0;
         memData <= 8'h00;
         waitCnt <= 2'h0;
         seenLoad <= 1'b0;
         strapDone <= 1'b0;
         strapAdcValid <= 1'b0;
         strapAdcValue <= 10'h000;
      end else begin
         memValid <= 1'b0;
         memData <= ~memData;
         strapAdcValid <= 1'b0;
         strapAdcValue <= ~strapAdcValue;
         if (memRead) seenLoad <= 1'b1;
         if (memRead && !memValid && memAddr <= MEM_IDX_LAST) begin
            if (waitCnt == 2'h0) begin
               memValid <= 1'b1;
               memData <= memImage[int'(memAddr) * 8 +: 8];
               waitCnt <= slow ? 2'h3 : 2'h0;
            end else begin
               waitCnt <= waitCnt - 2'h1;
            end
         end
         if (seenLoad && !memRead && !strapDone) begin
            strapAdcValid <= 1'b1;
            strapAdcValue <= strapCode;
            strapDone <= 1'b1;
         end
      end
   end
endmodule : rss_far_side_model

/* rss_sequencer_tb.sv */
// self-checking testbench of the startup sequencer
`timescale 1ns/1ps
module rss_sequencer_tb import rss_pkg::*;;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic ref_clk = 1'b0, rst = 1'b1, mainRailGood = 1'b1;
   logic coreRailGood = 1'b1, oscStable = 1'b0, enablePin = 1'b0;
   logic vinAboveOn = 1'b0, vinBelowOff = 1'b0, strapFloating = 1'b0;
   logic [9:0] strapAdcValue, vinAdcValue = 10'h2b4, strapCode = 10'h0c0;
   logic strapAdcValid, memValid, cmdValid = 1'b0, cmdWrite = 1'b0;
   logic [7:0] memData, cmdReg = 8'h00, cmdWrData = 8'h00;
   logic [6:0] cmdTarget = 7'h00;
   logic highSideGate = 1'b0, periodStart = 1'b0, slow = 1'b0;
   logic [39:0] memImage = 40'h0608004010;
   logic porActive, memRead, digitalMode, commPinsAnalog, cmdAck;
   logic convEnable, lowSideOn;
   logic [2:0] memAddr;
   logic [6:0] i2cAddr, smbusAddr;
   logic [7:0] vinOnLimit, vinOffLimit, cmdRdData;
   logic [3:0] lowSideDuty;
   int n_errors = 0, n_checks = 0;
   always #5 ref_clk = ~ref_clk;
   rss_sequencer u_rss_sequencer (.ref_clk(ref_clk), .rst(rst),
      .mainRailGood(mainRailGood), .coreRailGood(coreRailGood),
      .oscStable(oscStable), .enablePin(enablePin),
      .vinAboveOn(vinAboveOn), .vinBelowOff(vinBelowOff),
      .strapFloating(strapFloating), .strapAdcValue(strapAdcValue),
      .strapAdcValid(strapAdcValid), .vinAdcValue(vinAdcValue),
      .memData(memData), .memValid(memValid), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdTarget(cmdTarget), .cmdReg(cmdReg),
      .cmdWrData(cmdWrData), .highSideGate(highSideGate),
      .periodStart(periodStart), .porActive(porActive),
      .memRead(memRead), .memAddr(memAddr), .i2cAddr(i2cAddr),
      .smbusAddr(smbusAddr), .digitalMode(digitalMode),
      .commPinsAnalog(commPinsAnalog), .vinOnLimit(vinOnLimit),
      .vinOffLimit(vinOffLimit), .cmdAck(cmdAck), .cmdRdData(cmdRdData),
      .convEnable(convEnable), .lowSideOn(lowSideOn),
      .lowSideDuty(lowSideDuty));
   rss_far_side_model u_rss_far_side_model (.ref_clk(ref_clk), .rst(rst),
      .memRead(memRead), .memAddr(memAddr), .slow(slow),
      .memImage(memImage), .strapCode(strapCode), .memData(memData),
      .memValid(memValid), .strapAdcValue(strapAdcValue),
      .strapAdcValid(strapAdcValid));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic summarize;
      if (n_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // sel 0 memRead, 1 convEnable, 2 porActive, 3 mode latched
   task automatic waitLevel(input int sel, input logic lvl);
      logic s;
      for (int i = 0; i < 300; i++) begin
         @(posedge ref_clk);
         #1;
         case (sel)
            0: s = memRead;
            1: s = convEnable;
            2: s = porActive;
            default: s = digitalMode | commPinsAnalog;
         endcase
         if (s === lvl) return;
      end
      n_errors++;
      summarize();
   endtask : waitLevel
   task automatic boot(input logic [9:0] strap, input logic floatIt);
      @(posedge ref_clk);
      rst <= 1'b1;
      strapCode <= strap;
      strapFloating <= floatIt;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      waitLevel(0, 1'b1);
      waitLevel(0, 1'b0);
      waitLevel(3, 1'b1);
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : boot
   task automatic cmd(input logic wr, input logic [6:0] tgt,
         input logic [7:0] rg, input logic [7:0] wd, input logic expAck,
         input logic [7:0] expRd);
      @(posedge ref_clk);
      cmdValid <= 1'b1;
      cmdWrite <= wr;
      cmdTarget <= tgt;
      cmdReg <= rg;
      cmdWrData <= wd;
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      #1;
      chk({9'h000, cmdAck}, {9'h000, expAck});
      if (expAck && !wr) chk({2'h0, cmdRdData}, {2'h0, expRd});
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : cmd
   task automatic pulse(input int n, input logic gate);
      repeat (n) begin
         @(posedge ref_clk);
         periodStart <= !gate;
         highSideGate <= gate;
         @(posedge ref_clk);
         periodStart <= 1'b0;
         highSideGate <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : pulse
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk({3'h0, i2cAddr}, 10'h010);
      chk({3'h0, smbusAddr}, 10'h040);
      chk({2'h0, vinOnLimit}, 10'h004);
      repeat (20) @(posedge ref_clk);
      #1;
      chk({8'h00, porActive, memRead}, 10'h002);
      @(posedge ref_clk);
      oscStable <= 1'b1;
      waitLevel(0, 1'b1);
      boot(10'h0c0, 1'b0);
      chk({7'h00, memAddr}, 10'h004);
      chk({3'h0, i2cAddr}, 10'h013);
      chk({3'h0, smbusAddr}, 10'h043);
      chk({vinOnLimit, 2'h0}, {8'h08, 2'h0});
      chk({2'h0, vinOffLimit}, 10'h006);
      chk({8'h00, digitalMode, commPinsAnalog}, 10'h002);
      cmd(1'b0, 7'h13, REG_I2C_BASE, 8'h00, 1'b1, 8'h10);
      cmd(1'b0, 7'h43, REG_SMBUS_BASE, 8'h00, 1'b1, 8'h40);
      cmd(1'b0, 7'h13, REG_STATUS, 8'h00, 1'b1, {6'h02, ST_READY});
      cmd(1'b0, 7'h14, REG_I2C_BASE, 8'h00, 1'b0, 8'h00);
      cmd(1'b1, 7'h13, REG_VIN_ON, 8'h0a, 1'b1, 8'h00);
      chk({2'h0, vinOnLimit}, 10'h00a);
      cmd(1'b0, 7'h13, REG_VIN_OFF, 8'h00, 1'b1, 8'h06);
      cmd(1'b0, 7'h13, REG_READ_VIN, 8'h00, 1'b1, 8'had);
      cmd(1'b1, 7'h43, REG_SMBUS_BASE, 8'h00, 1'b1, 8'h00);
      cmd(1'b0, smbusAddr, REG_I2C_BASE, 8'h00, 1'b0, 8'h00);
      @(posedge ref_clk);
      enablePin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      chk({9'h000, convEnable}, 10'h000);
      @(posedge ref_clk);
      vinAboveOn <= 1'b1;
      waitLevel(1, 1'b1);
      @(posedge ref_clk);
      vinAdcValue <= 10'h000;
      repeat (8) @(posedge ref_clk);
      #1;
      chk({9'h000, convEnable}, 10'h001);
      cmd(1'b1, 7'h13, REG_ONOFF, 8'h01, 1'b1, 8'h00);
      waitLevel(1, 1'b0);
      cmd(1'b1, 7'h13, REG_ONOFF, 8'h03, 1'b1, 8'h00);
      waitLevel(1, 1'b1);
      cmd(1'b0, 7'h13, REG_ONOFF, 8'h00, 1'b1, 8'h03);
      pulse(3, 1'b0);
      chk({9'h000, lowSideOn}, 10'h000);
      pulse(1, 1'b1);
      chk({5'h00, lowSideOn, lowSideDuty}, 10'h011);
      for (int d = 2; d <= 9; d++) begin
         pulse(16, 1'b0);
         chk({6'h00, lowSideDuty}, (d > 8) ? 10'h008 : 10'(d));
      end
      @(posedge ref_clk);
      coreRailGood <= 1'b0;
      waitLevel(2, 1'b1);
      waitLevel(1, 1'b0);
      @(posedge ref_clk);
      coreRailGood <= 1'b1;
      for (int k = 0; k < STRAP_BINS; k++) begin
         slow <= k[0];
         boot(10'(k * 64), 1'b0);
         chk({3'h0, i2cAddr}, 10'(16 + k));
      end
      boot(10'h0c0, 1'b1);
      chk({8'h00, digitalMode, commPinsAnalog}, 10'h001);
      cmd(1'b1, 7'h13, REG_VIN_ON, 8'h0a, 1'b0, 8'h00);
      chk({2'h0, vinOnLimit}, 10'h008);
      summarize();
   end
endmodule : rss_sequencer_tb
